// ==== bench/pmcr_tb.sv ====
// Self-checking bench for the control register bank, driven over APB
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmcr_pkg::*;
   // ****************************************************************
   // Signals and design instance
   // ****************************************************************
   localparam logic [7:0] IDXS [8] = '{IDX_DISCH, IDX_MEAS, IDX_ISRC, IDX_RATE, IDX_TMR, IDX_DEB,
      IDX_SHDN, IDX_GP0};
   localparam logic [7:0] RSTS [8] = '{RST_DISCH, RST_MEAS, RST_ISRC, RST_RATE, RST_TMR, RST_DEB,
      RST_SHDN, RST_GP0};
   // Timer writable view is the threshold only, status clears on a one
   localparam logic [7:0] WMS [8] = '{WM_DISCH, WM_MEAS, WM_ISRC, WM_RATE, 8'h7f, WM_DEB, WM_SHDN,
      WM_GP0};
   logic pclk, presetn, sys_rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] step_down_low, step_down_off, discharge_en;
   logic die_warn3, power_key, charging, conv_phase, batt_temp_ok, sleep_wake, gp0_in;
   logic gp0_out, gp0_oe, gp0_ldo_en, ts_isrc_on, charge_temp_block, key_por_req;
   logic restore_boot, irq, err;
   logic [4:0] conv_enable;
   logic [1:0] gp0_isrc_code, ts_isrc_code, slow_rate_code, fast_rate_code;
   pmcr_shdn_t shutdown_req;
   int error_cnt = 0;
   int cmp_count = 0;
   int n;

   // Short tick and hold counts keep the timer and key tests brief
   pmcr_ctrl #(.DEB_STEP(2), .TICK(4), .KEY_TICKS(3)) dut (.pclk(pclk), .presetn(presetn),
      .sys_rst_n(sys_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .step_down_low(step_down_low), .step_down_off(step_down_off), .die_warn3(die_warn3),
      .power_key(power_key), .charging(charging), .conv_phase(conv_phase),
      .batt_temp_ok(batt_temp_ok), .sleep_wake(sleep_wake), .general_pin_zero_in(gp0_in),
      .general_pin_zero_out(gp0_out), .general_pin_zero_oe(gp0_oe), .gp0_ldo_en(gp0_ldo_en),
      .conv_enable(conv_enable), .gp0_isrc_code(gp0_isrc_code), .ts_isrc_code(ts_isrc_code),
      .ts_isrc_on(ts_isrc_on), .slow_rate_code(slow_rate_code), .fast_rate_code(fast_rate_code),
      .charge_temp_block(charge_temp_block), .discharge_en(discharge_en),
      .shutdown_req(shutdown_req), .key_por_req(key_por_req), .restore_boot(restore_boot),
      .irq(irq));

   // ****************************************************************
   // Clock, bus tasks and run control
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // No cycle limit here: a lost answer is caught by the watchdog
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, ad(i), d);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [7:0] e);
      apb(1'b0, ad(i), 8'h00);
      `CHK(rd, {24'h0, e})
   endtask
   // Outputs are registered; a few edges let every update land
   task automatic settle();
      repeat (3) @(posedge pclk);
   endtask
   task automatic end_test(input string s);
      $display("test %s finished", s);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Whole sequence needs well under a thousand cycles; this margin catches a hang
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      complete_run();
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      {psel, penable, pwrite, presetn, sys_rst_n} = 5'b00001;
      paddr = 12'h000;
      pwdata = 32'h0;
      {step_down_low, step_down_off} = {6'h00, 6'h3f};
      {die_warn3, power_key, charging, conv_phase, batt_temp_ok, sleep_wake, gp0_in} = 7'h04;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) rdc(IDXS[i], RSTS[i]);
      `CHK({ts_isrc_code, gp0_isrc_code}, 4'hf)
      `CHK({slow_rate_code, fast_rate_code}, 4'hb)
      `CHK(conv_enable, 5'h1d)
      `CHK(discharge_en, 6'h3f)
      `CHK(ts_isrc_on, 1'b0)
      end_test("reset values");
      for (int i = 0; i < 8; i++) begin
         wr(IDXS[i], 8'hff);
         rdc(IDXS[i], WMS[i]);
      end
      settle();
      `CHK(conv_enable, 5'h1f)
      apb(1'b1, 12'h3fc, 8'h00);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h3fc, 8'h55);
      `CHK({err, rd}, 33'h100000000)
      rdc(IDX_DISCH, WM_DISCH);
      end_test("access and unmapped");
      wr(IDX_DISCH, 8'h08);
      step_down_low <= 6'b111011;
      settle();
      `CHK({discharge_en, shutdown_req.undervolt}, 7'h00)
      step_down_low <= 6'b000100;
      settle();
      `CHK(shutdown_req.undervolt, 1'b0)
      repeat (9) @(posedge pclk);
      `CHK(shutdown_req.undervolt, 1'b1)
      step_down_low <= 6'h00;
      wr(IDX_DISCH, 8'h80);
      settle();
      `CHK(discharge_en, 6'h3f)
      end_test("discharge and undervoltage");
      for (int c = 0; c < 4; c++) begin
         wr(IDX_ISRC, {6'h3c, c[1:0]});
         for (int p = 0; p < 4; p++) begin
            {charging, conv_phase} <= p[1:0];
            settle();
            `CHK(ts_isrc_on, (c == 3) | (c == 1 & p[1]) | (c == 2 & p[0]))
         end
      end
      batt_temp_ok <= 1'b0;
      settle();
      `CHK(charge_temp_block, 1'b1)
      wr(IDX_ISRC, 8'h04);
      settle();
      `CHK(charge_temp_block, 1'b0)
      batt_temp_ok <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(IDX_ISRC, {c[1:0], ~c[1:0], 4'h0});
         wr(IDX_RATE, {c[1:0], ~c[1:0], 4'h0});
         settle();
         `CHK({gp0_isrc_code, ts_isrc_code}, {c[1:0], ~c[1:0]})
         `CHK({slow_rate_code, fast_rate_code}, {c[1:0], ~c[1:0]})
      end
      end_test("sense pin and rates");
      wr(IDX_TMR, 8'h80);
      wr(IDX_IRQ_STAT, 8'hff);
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_TMR, 8'h03);
      repeat (30) @(posedge pclk);
      rdc(IDX_TMR, 8'h83);
      `CHK(irq, 1'b1)
      wr(IDX_IRQ_MASK, 8'h00);
      settle();
      `CHK(irq, 1'b0)
      wr(IDX_TMR, 8'h80);
      rdc(IDX_TMR, 8'h00);
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_IRQ_STAT, 8'h01);
      repeat (60) @(posedge pclk);
      rdc(IDX_TMR, 8'h00);
      `CHK(irq, 1'b0)
      wr(IDX_TMR, 8'h08);
      repeat (20) @(posedge pclk);
      wr(IDX_TMR, 8'h88);
      repeat (20) @(posedge pclk);
      rdc(IDX_TMR, 8'h08);
      repeat (20) @(posedge pclk);
      rdc(IDX_TMR, 8'h88);
      wr(IDX_TMR, 8'h80);
      end_test("timer and interrupt");
      for (int c = 0; c < 5; c++) begin
         wr(IDX_GP0, {5'h00, c[2:0]});
         settle();
         `CHK(gp0_oe, c < 2)
         if (c < 2) `CHK(gp0_out, c[0])
         if (c > 2) `CHK(gp0_ldo_en, c == 3)
      end
      wr(IDX_GP0, 8'h82);
      wr(IDX_IRQ_STAT, 8'hff);
      wr(IDX_IRQ_MASK, 8'h04);
      gp0_in <= 1'b1;
      settle();
      `CHK(irq, 1'b1)
      wr(IDX_IRQ_STAT, 8'h04);
      gp0_in <= 1'b0;
      settle();
      `CHK(irq, 1'b0)
      wr(IDX_GP0, 8'h42);
      gp0_in <= 1'b1;
      settle();
      `CHK(irq, 1'b0)
      rdc(IDX_PIN_STAT, 8'h01);
      gp0_in <= 1'b0;
      settle();
      `CHK(irq, 1'b1)
      rdc(IDX_IRQ_STAT, 8'h04);
      rdc(IDX_IRQ_MASK, 8'h04);
      end_test("pin zero");
      {die_warn3, sleep_wake} <= 2'b11;
      wr(IDX_SHDN, 8'h04);
      settle();
      `CHK({shutdown_req.overtemp, restore_boot}, 2'b11)
      wr(IDX_SHDN, 8'h02);
      settle();
      `CHK({shutdown_req.overtemp, restore_boot}, 2'b00)
      wr(IDX_SHDN, 8'h08);
      power_key <= 1'b1;
      n = 0;
      while (key_por_req !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      `CHK({n > 8, n < 60}, 2'b11)
      power_key <= 1'b0;
      end_test("shutdown options");
      wr(IDX_DISCH, 8'h00);
      wr(IDX_GP0, 8'hc0);
      wr(IDX_TMR, 8'h05);
      sys_rst_n <= 1'b0;
      repeat (2) @(posedge pclk);
      sys_rst_n <= 1'b1;
      rdc(IDX_GP0, RST_GP0);
      rdc(IDX_TMR, RST_TMR);
      rdc(IDX_DISCH, 8'h00);
      end_test("system reset");
      complete_run();
   end
endmodule

// ==== logic/pmcr_ctrl.sv ====
// Control register bank: APB slave, discharge/monitor, measurement, timer, pin 0
//
// Contract
// - Discharge outputs on turn-off while enabled
// - Per-converter 85% undervoltage shutdown enables
// - Convert channel only while enabled
// - Two-bit bias current codes, default eighty uA
// - Sense pin role gates charger temperature input
// - Sense current source switching by code
// - Sense/pin0 sample rate 25 times 2^n
// - Battery sample rate 100 times 2^n
// - Zero threshold disables timer
// - Timeout sets status; write one clears it and restarts the count
// - Monitor debounce 62us steps by code
// - Sixteen second key hold triggers reset
// - Overtemperature level 3 shutdown option
// - Wake recovery restores boot voltage option
// - Pin 0 edge interrupts when input
// - Pin 0 three-bit function code
// - Floating pin 0 with enable is conversion input
// - Power-on versus system reset domains
module pmcr_ctrl #(
   parameter int DEB_STEP = pmcr_pkg::DEB_STEP_CYC,
   parameter int TICK = pmcr_pkg::TICK_CYC,
   parameter int KEY_TICKS = pmcr_pkg::KEY_HOLD_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sys_rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] step_down_low,
   input wire logic [5:0] step_down_off,
   input wire logic die_warn3,
   input wire logic power_key,
   input wire logic charging,
   input wire logic conv_phase,
   input wire logic batt_temp_ok,
   input wire logic sleep_wake,
   input wire logic general_pin_zero_in,
   output logic general_pin_zero_out,
   output logic general_pin_zero_oe,
   output logic gp0_ldo_en,
   output logic [4:0] conv_enable,
   output logic [1:0] gp0_isrc_code,
   output logic [1:0] ts_isrc_code,
   output logic ts_isrc_on,
   output logic [1:0] slow_rate_code,
   output logic [1:0] fast_rate_code,
   output logic charge_temp_block,
   output logic [5:0] discharge_en,
   output pmcr_pkg::pmcr_shdn_t shutdown_req,
   output logic key_por_req,
   output logic restore_boot,
   output logic irq
);
   import pmcr_pkg::*;

   // Counters are 20 and 16 bits wide; larger settings would wrap silently
   if (DEB_STEP < 1 || DEB_STEP > 2 ** 18 - 1 || TICK < 1 || TICK > 2 ** 20 ||
      KEY_TICKS < 1 || KEY_TICKS > 2 ** 16) begin : g_param_check
      $error("pmcr_ctrl: bad timing parameter");
   end

   typedef struct packed {
      logic [7:0] disch;
      logic [7:0] meas;
      logic [7:0] isrc;
      logic [7:0] rate;
      logic [7:0] deb;
      logic [7:0] shdn;
      logic [7:0] tmr;
      logic [7:0] gp0;
      logic [NUM_IRQ-1:0] ist;
      logic [NUM_IRQ-1:0] imsk;
      logic [19:0] tick_cnt;
      logic [6:0] tmr_cnt;
      logic [19:0] deb_cnt;
      logic [15:0] key_cnt;
      logic gp0_prev;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic irq;
      logic gp_out;
      logic gp_oe;
      logic ldo;
      logic [4:0] cen;
      logic ts_on;
      logic tblk;
      logic [5:0] dis;
      pmcr_shdn_t shd;
      logic kpor;
      logic rboot;
   } pmcr_state_t;

   pmcr_state_t s_q, s_d;

   // Word index decode shared by read and write
   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      return (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return hit(a, IDX_DISCH) || hit(a, IDX_MEAS) || hit(a, IDX_ISRC) ||
         hit(a, IDX_RATE) || hit(a, IDX_TMR) || hit(a, IDX_DEB) ||
         hit(a, IDX_SHDN) || hit(a, IDX_GP0) || hit(a, IDX_IRQ_STAT) ||
         hit(a, IDX_IRQ_MASK) || hit(a, IDX_PIN_STAT);
   endfunction

   logic setup, wr, rd;
   logic [6:0] thr;
   logic timeout, uv_hit, gp_edge, key_fire, gp_float;
   logic [19:0] deb_lim;
   logic [NUM_IRQ-1:0] ev;

   // ********************************************************************
   // Next-state logic
   // ********************************************************************
   always_comb begin
      s_d = s_q;
      // Answer one cycle after setup: pready rises in the first access cycle
      setup = psel && !penable;
      wr = psel && penable && s_q.ready && pwrite;
      rd = setup && !pwrite;
      s_d.ready = setup;
      s_d.err = setup && !mapped(paddr);
      thr = s_q.tmr[6:0];

      // Fixed tick divider shared by the timer and the key-hold counter
      s_d.tick_cnt = (s_q.tick_cnt == 20'(TICK - 1)) ? 20'h0 : s_q.tick_cnt + 20'h1;
      // Timer counts ticks while the threshold is nonzero and no timeout status is pending
      timeout = 1'b0;
      if (thr == 7'h0) begin
         s_d.tmr_cnt = 7'h0;
      end else if (s_q.tick_cnt == 20'(TICK - 1) && !s_q.tmr[B_TMR_STAT]) begin
         if (s_q.tmr_cnt + 7'h1 >= thr) begin
            timeout = 1'b1;
            s_d.tmr_cnt = 7'h0;
         end else begin
            s_d.tmr_cnt = s_q.tmr_cnt + 7'h1;
         end
      end

      // Debounce: low flag must hold (code+1)*62us before shutdown
      deb_lim = 20'(DEB_STEP) * ({18'h0, s_q.deb[7:6]} + 20'h1);
      uv_hit = 1'b0;
      if ((step_down_low & {s_q.disch[6:3], s_q.disch[1:0]}) != 6'h0) begin
         if (s_q.deb_cnt >= deb_lim - 20'h1) begin
            uv_hit = 1'b1;
         end else begin
            s_d.deb_cnt = s_q.deb_cnt + 20'h1;
         end
      end else begin
         s_d.deb_cnt = 20'h0;
      end

      // Long key hold counted in ticks
      key_fire = 1'b0;
      if (!power_key || !s_q.shdn[B_LONGKEY]) begin
         s_d.key_cnt = 16'h0;
      end else if (s_q.tick_cnt == 20'(TICK - 1)) begin
         if (s_q.key_cnt == 16'(KEY_TICKS - 1)) begin
            key_fire = 1'b1;
         end else begin
            s_d.key_cnt = s_q.key_cnt + 16'h1;
         end
      end

      // Pin 0 edge detect only in digital-input mode
      s_d.gp0_prev = general_pin_zero_in;
      gp_edge = (s_q.gp0[2:0] == GP_IN) &&
         ((s_q.gp0[B_GP0_RISE] && general_pin_zero_in && !s_q.gp0_prev) ||
          (s_q.gp0[B_GP0_FALL] && !general_pin_zero_in && s_q.gp0_prev));

      ev = '0;
      ev[IRQ_TMR] = timeout;
      ev[IRQ_UV] = uv_hit;
      ev[IRQ_GP0] = gp_edge;
      ev[IRQ_KEY] = key_fire;

      // Register writes
      if (wr) begin
         if (hit(paddr, IDX_DISCH)) s_d.disch = pwdata[7:0] & WM_DISCH;
         if (hit(paddr, IDX_MEAS)) s_d.meas = pwdata[7:0] & WM_MEAS;
         if (hit(paddr, IDX_ISRC)) s_d.isrc = pwdata[7:0] & WM_ISRC;
         if (hit(paddr, IDX_RATE)) s_d.rate = pwdata[7:0] & WM_RATE;
         if (hit(paddr, IDX_DEB)) s_d.deb = pwdata[7:0] & WM_DEB;
         if (hit(paddr, IDX_SHDN)) s_d.shdn = pwdata[7:0] & WM_SHDN;
         if (hit(paddr, IDX_GP0)) s_d.gp0 = pwdata[7:0] & WM_GP0;
         if (hit(paddr, IDX_IRQ_MASK)) s_d.imsk = pwdata[NUM_IRQ-1:0];
         if (hit(paddr, IDX_IRQ_STAT)) s_d.ist = s_q.ist & ~pwdata[NUM_IRQ-1:0];
         if (hit(paddr, IDX_TMR)) begin
            s_d.tmr[6:0] = pwdata[6:0];
            if (pwdata[B_TMR_STAT]) begin
               s_d.tmr[B_TMR_STAT] = 1'b0;
               s_d.tmr_cnt = 7'h0;
            end
         end
      end
      // Events win over a clear in the same cycle
      if (timeout) s_d.tmr[B_TMR_STAT] = 1'b1;
      s_d.ist = s_d.ist | ev;

      // Read data captured at setup, stable through access
      s_d.rdata = 32'h0;
      if (rd) begin
         if (hit(paddr, IDX_DISCH)) s_d.rdata[7:0] = s_q.disch;
         if (hit(paddr, IDX_MEAS)) s_d.rdata[7:0] = s_q.meas;
         if (hit(paddr, IDX_ISRC)) s_d.rdata[7:0] = s_q.isrc;
         if (hit(paddr, IDX_RATE)) s_d.rdata[7:0] = s_q.rate;
         if (hit(paddr, IDX_TMR)) s_d.rdata[7:0] = s_q.tmr;
         if (hit(paddr, IDX_DEB)) s_d.rdata[7:0] = s_q.deb;
         if (hit(paddr, IDX_SHDN)) s_d.rdata[7:0] = s_q.shdn;
         if (hit(paddr, IDX_GP0)) s_d.rdata[7:0] = s_q.gp0;
         if (hit(paddr, IDX_IRQ_STAT)) s_d.rdata[NUM_IRQ-1:0] = s_q.ist;
         if (hit(paddr, IDX_IRQ_MASK)) s_d.rdata[NUM_IRQ-1:0] = s_q.imsk;
         if (hit(paddr, IDX_PIN_STAT)) s_d.rdata[0] = s_q.gp0_prev;
      end

      // Pin 0 function decode
      gp_float = (s_q.gp0[2:0] > GP_LDO_OFF);
      s_d.gp_out = (s_q.gp0[2:0] == GP_HIGH);
      s_d.gp_oe = (s_q.gp0[2:0] == GP_LOW) || (s_q.gp0[2:0] == GP_HIGH);
      if (s_q.gp0[2:0] == GP_LDO_ON) s_d.ldo = 1'b1;
      if (s_q.gp0[2:0] == GP_LDO_OFF) s_d.ldo = 1'b0;
      // Channel enables: vbat, ibat, die, pin0, sense pin
      s_d.cen = {s_q.meas[B_MEAS_VBAT], s_q.meas[B_MEAS_IBAT], s_q.meas[B_MEAS_DIE],
         s_q.meas[B_MEAS_GP0] && gp_float, s_q.meas[B_MEAS_TS]};
      // Sense current source switching
      case (s_q.isrc[1:0])
         TS_OFF: s_d.ts_on = 1'b0;
         TS_CHG: s_d.ts_on = charging;
         TS_CONV: s_d.ts_on = conv_phase;
         default: s_d.ts_on = 1'b1;
      endcase
      // Charger sees sense pin only in battery-temperature role
      s_d.tblk = !s_q.isrc[B_TS_ROLE] && !batt_temp_ok;
      s_d.dis = s_q.disch[B_DISCH_EN] ? step_down_off : 6'h0;
      s_d.shd.undervolt = uv_hit;
      s_d.shd.overtemp = s_q.shdn[B_OTSHDN] && die_warn3;
      s_d.shd.key_reset = 1'b0;
      s_d.kpor = key_fire;
      s_d.rboot = sleep_wake && !s_q.shdn[B_VRECOV];
      s_d.irq = |(s_d.ist & s_q.imsk);
   end

   // ********************************************************************
   // State registers: power-on fields vs system-reset fields
   // ********************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.disch <= RST_DISCH;
         s_q.meas <= RST_MEAS;
         s_q.isrc <= RST_ISRC;
         s_q.rate <= RST_RATE;
         s_q.deb <= RST_DEB;
         s_q.shdn <= RST_SHDN;
         s_q.tmr <= RST_TMR;
         s_q.gp0 <= RST_GP0;
      end else if (!sys_rst_n) begin
         s_q <= s_d;
         s_q.tmr <= RST_TMR;
         s_q.tmr_cnt <= 7'h0;
         s_q.gp0 <= RST_GP0;
      end else begin
         s_q <= s_d;
      end
   end

   // ********************************************************************
   // Outputs straight from flip-flops
   // ********************************************************************
   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.err;
   assign irq = s_q.irq;
   assign general_pin_zero_out = s_q.gp_out;
   assign general_pin_zero_oe = s_q.gp_oe;
   assign gp0_ldo_en = s_q.ldo;
   assign conv_enable = s_q.cen;
   assign gp0_isrc_code = s_q.isrc[7:6];
   assign ts_isrc_code = s_q.isrc[5:4];
   assign ts_isrc_on = s_q.ts_on;
   assign slow_rate_code = s_q.rate[7:6];
   assign fast_rate_code = s_q.rate[5:4];
   assign charge_temp_block = s_q.tblk;
   assign discharge_en = s_q.dis;
   assign shutdown_req = s_q.shd;
   assign key_por_req = s_q.kpor;
   assign restore_boot = s_q.rboot;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   // Outputs lag their fields by one edge, hence the $past terms
   AST_DISCH: assert property (@(posedge pclk) disable iff (!presetn)
      !s_q.disch[B_DISCH_EN] |=> discharge_en == 6'h0)
      else $error("discharge while disabled");
   AST_DISEN: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.disch[B_DISCH_EN] |=> discharge_en == $past(step_down_off))
      else $error("discharge does not follow converter off");
   AST_UV: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_req.undervolt |-> $past(s_q.disch[6:3] != 4'h0 || s_q.disch[1:0] != 2'h0))
      else $error("undervolt shutdown without enable");
   AST_DEB: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_req.undervolt |-> $past(s_q.deb_cnt >= deb_lim - 20'h1))
      else $error("undervolt shutdown before debounce time");
   AST_CONV: assert property (@(posedge pclk) disable iff (!presetn)
      conv_enable[0] |-> $past(s_q.meas[B_MEAS_TS]))
      else $error("sense channel converts while off");
   AST_CEN: assert property (@(posedge pclk) disable iff (!presetn)
      conv_enable[1] |-> $past(s_q.meas[B_MEAS_GP0] && s_q.gp0[2:0] > GP_LDO_OFF))
      else $error("pin 0 converts outside floating mode");
   AST_TSOFF: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.isrc[1:0] == TS_OFF) [*2] |-> !ts_isrc_on)
      else $error("sense current on while off");
   AST_TSCHG: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.isrc[1:0] == TS_CHG) [*2] |-> ts_isrc_on == $past(charging))
      else $error("sense current not following charging");
   AST_TSCONV: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.isrc[1:0] == TS_CONV) [*2] |-> ts_isrc_on == $past(conv_phase))
      else $error("sense current not following conversion phase");
   AST_TSON: assert property (@(posedge pclk) disable iff (!presetn)
      (&s_q.isrc[1:0]) [*2] |-> ts_isrc_on)
      else $error("sense current off while always on");
   AST_TBLK: assert property (@(posedge pclk) disable iff (!presetn)
      charge_temp_block |-> $past(!s_q.isrc[B_TS_ROLE] && !batt_temp_ok))
      else $error("charger blocked outside temperature role");
   AST_TMR0: assert property (@(posedge pclk) disable iff (!presetn || !sys_rst_n)
      s_q.tmr[6:0] == 7'h0 |=> s_q.tmr_cnt == 7'h0)
      else $error("timer runs with zero threshold");
   AST_TMRSET: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_q.tmr[B_TMR_STAT]) |-> $past(s_q.tmr[6:0] != 7'h0))
      else $error("timeout with timer disabled");
   AST_TCLR: assert property (@(posedge pclk) disable iff (!presetn || !sys_rst_n)
      wr && hit(paddr, IDX_TMR) && pwdata[B_TMR_STAT] && !timeout
      |=> !s_q.tmr[B_TMR_STAT])
      else $error("timer status not cleared");
   AST_TCNT: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.tmr[B_TMR_STAT] |-> s_q.tmr_cnt == 7'h0)
      else $error("timer counts while timeout pending");
   AST_KEY: assert property (@(posedge pclk) disable iff (!presetn)
      key_por_req |-> $past(s_q.shdn[B_LONGKEY] && power_key))
      else $error("key reset without enabled key hold");
   AST_OT: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_req.overtemp |-> $past(die_warn3) && $past(s_q.shdn[B_OTSHDN]))
      else $error("overtemp shutdown not requested");
   AST_RBOOT: assert property (@(posedge pclk) disable iff (!presetn)
      restore_boot |-> $past(sleep_wake && !s_q.shdn[B_VRECOV]))
      else $error("boot voltage restored while recovery off");
   AST_GPEDGE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_q.ist[IRQ_GP0]) |-> $past(s_q.gp0[2:0] == GP_IN))
      else $error("pin 0 edge outside input mode");
   AST_GPOE: assert property (@(posedge pclk) disable iff (!presetn)
      general_pin_zero_oe |-> $past(s_q.gp0[2:1] == 2'h0))
      else $error("pin 0 driven in non-drive mode");
   AST_GPOUT: assert property (@(posedge pclk) disable iff (!presetn)
      general_pin_zero_out |-> $past(s_q.gp0[2:0] == GP_HIGH))
      else $error("pin 0 high outside drive-high mode");
   AST_LDO: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(gp0_ldo_en) |-> $past(s_q.gp0[2:0] == GP_LDO_ON))
      else $error("pin 0 regulator on without code");
   AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      irq |-> (s_q.ist & $past(s_q.imsk)) != '0)
      else $error("interrupt without unmasked status");
endmodule

// ==== logic/pmcr_pkg.sv ====
// Package: register map, field positions, reset values and timing for the control bank
package pmcr_pkg;
   // ********************************************************************
   // Register word indices (APB word per register, byte address is index times four)
   // ********************************************************************
   localparam logic [7:0] IDX_DISCH = 8'h81;
   localparam logic [7:0] IDX_MEAS = 8'h82;
   localparam logic [7:0] IDX_ISRC = 8'h84;
   localparam logic [7:0] IDX_RATE = 8'h85;
   localparam logic [7:0] IDX_TMR = 8'h8a;
   localparam logic [7:0] IDX_DEB = 8'h8e;
   localparam logic [7:0] IDX_SHDN = 8'h8f;
   localparam logic [7:0] IDX_GP0 = 8'h90;
   localparam logic [7:0] IDX_IRQ_STAT = 8'ha0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'ha1;
   localparam logic [7:0] IDX_PIN_STAT = 8'ha2;
   // ********************************************************************
   // Reset values
   // ********************************************************************
   localparam logic [7:0] RST_DISCH = 8'h80;
   localparam logic [7:0] RST_MEAS = 8'he1;
   localparam logic [7:0] RST_ISRC = 8'hf2;
   localparam logic [7:0] RST_RATE = 8'hb0;
   localparam logic [7:0] RST_TMR = 8'h00;
   localparam logic [7:0] RST_DEB = 8'h40;
   localparam logic [7:0] RST_SHDN = 8'h00;
   localparam logic [7:0] RST_GP0 = 8'h07;
   // Writable bits (reserved read as zero)
   localparam logic [7:0] WM_DISCH = 8'hfb;
   localparam logic [7:0] WM_MEAS = 8'hf1;
   localparam logic [7:0] WM_ISRC = 8'hf7;
   localparam logic [7:0] WM_RATE = 8'hf4;
   localparam logic [7:0] WM_DEB = 8'hc0;
   localparam logic [7:0] WM_SHDN = 8'h0e;
   localparam logic [7:0] WM_GP0 = 8'hc7;
   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int B_DISCH_EN = 7;
   localparam int B_MEAS_VBAT = 7;
   localparam int B_MEAS_IBAT = 6;
   localparam int B_MEAS_DIE = 5;
   localparam int B_MEAS_GP0 = 4;
   localparam int B_MEAS_TS = 0;
   localparam int B_TS_ROLE = 2;
   localparam int B_TMR_STAT = 7;
   localparam int B_LONGKEY = 3;
   localparam int B_OTSHDN = 2;
   localparam int B_VRECOV = 1;
   localparam int B_GP0_RISE = 7;
   localparam int B_GP0_FALL = 6;
   localparam int NUM_IRQ = 4;
   localparam int IRQ_TMR = 0;
   localparam int IRQ_UV = 1;
   localparam int IRQ_GP0 = 2;
   localparam int IRQ_KEY = 3;
   // Pin function codes
   localparam logic [2:0] GP_LOW = 3'h0;
   localparam logic [2:0] GP_HIGH = 3'h1;
   localparam logic [2:0] GP_IN = 3'h2;
   localparam logic [2:0] GP_LDO_ON = 3'h3;
   localparam logic [2:0] GP_LDO_OFF = 3'h4;
   // Current-source switching codes
   localparam logic [1:0] TS_OFF = 2'h0;
   localparam logic [1:0] TS_CHG = 2'h1;
   localparam logic [1:0] TS_CONV = 2'h2;
   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam int CLK_MHZ = 125;
   localparam int DEB_STEP_US = 62;
   localparam int DEB_STEP_CYC = DEB_STEP_US * CLK_MHZ;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int KEY_HOLD_S = 16;
   localparam int KEY_HOLD_TICKS = KEY_HOLD_S * 1000;

   // Shutdown causes
   typedef struct packed {
      logic undervolt;
      logic overtemp;
      logic key_reset;
   } pmcr_shdn_t;
endpackage
